/* scsq_pkg.sv */
package scsq_pkg;

   // Reference clock of the card link and the card clock made from it
   localparam int REF_CLK_HZ = 8_000_000;
   localparam int CARD_CLK_HZ = 4_000_000;
   localparam logic [3:0] CARD_HALF_DIV = 4'(REF_CLK_HZ / (2 * CARD_CLK_HZ));

   // Card clock cycles per data bit, and half of it for the start bit check
   localparam logic [15:0] ETU_CYC = 16'h0174;
   localparam logic [8:0] ETU_HALF_CYC = 9'(ETU_CYC / 16'h0002);

   // Activation timing in card clock cycles, except POWER_UP_CYC in reference clock cycles
   localparam logic [15:0] POWER_UP_CYC = 16'h0008;
   localparam logic [15:0] DATA_REL_CYC = 16'h0064;
   localparam logic [15:0] DATA_MAX_CYC = 16'h00C8;
   localparam logic [15:0] ATR_MIN_CYC = 16'h0190;
   localparam logic [15:0] ATR_MAX_CYC = 16'h9C40;
   localparam logic [15:0] RST_HOLD_CYC = 16'h9C40;

   // Counter value that wraps to zero on the first card clock edge (T0)
   localparam logic [15:0] CNT_PRE_T0 = 16'hFFFF;

   // Link sequencer states
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_POWER = 3'b001,
      L_WAIT_T0 = 3'b010,
      L_WAIT_T1 = 3'b011,
      L_VERIFY = 3'b100,
      L_DONE = 3'b101
   } scsq_lstate_t;

endpackage

/* scsq_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module scsq_sync3 #(
   parameter int W = 1
) (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [W-1:0] din, // Asynchronous input
   output logic [W-1:0] dout // Filtered value
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } scsq_sync_t;

   scsq_sync_t s_reg;
   scsq_sync_t s_next;

   // Three stage chain; a bit changes once stages two and three agree
   always_comb begin
      s_next = s_reg;
      s_next.s1 = din;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (s_reg.s2[i] == s_reg.s3[i]) begin
            s_next.q[i] = s_reg.s3[i];
         end
      end
      if (rst) begin
         s_next.q = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   assign dout = s_reg.q;
endmodule // scsq_sync3
`default_nettype wire

/* scsq_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module scsq_clkdiv
   import scsq_pkg::*;
(
   input wire logic clk, // Link reference clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic run, // Card clock enable
   output logic clk_out, // Card clock, 50% duty
   output logic rise // Pulse in the cycle the card clock goes high
);
   typedef struct packed {
      logic [3:0] cnt;
      logic clk_out;
      logic rise;
   } scsq_div_t;

   scsq_div_t d_reg;
   scsq_div_t d_next;

   // Equal half periods; the clock parks low when stopped
   always_comb begin
      d_next = d_reg;
      d_next.rise = 1'b0;
      if (!run) begin
         d_next.cnt = 4'h0;
         d_next.clk_out = 1'b0;
      end else if (d_reg.cnt == CARD_HALF_DIV - 4'h1) begin
         d_next.cnt = 4'h0;
         d_next.clk_out = ~d_reg.clk_out;
         d_next.rise = ~d_reg.clk_out;
      end else begin
         d_next.cnt = d_reg.cnt + 4'h1;
      end
      if (rst) begin
         d_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      d_reg <= d_next;
   end

   assign clk_out = d_reg.clk_out;
   assign rise = d_reg.rise;
endmodule // scsq_clkdiv
`default_nettype wire

/* scsq_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scsq_top
   import scsq_pkg::*;
#(
   parameter logic [15:0] ATR_MAX = ATR_MAX_CYC,
   parameter logic [15:0] RST_HOLD = RST_HOLD_CYC
) (
   input wire logic mclk, // System clock, 125 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic act_start, // Pulse: start card activation
   input wire logic act_stop, // Pulse: end the card session
   input wire logic cfg_low_reset, // Level: 1 for active-low reset card
   output logic atr_ok, // Pulse: timely answer to reset seen
   output logic atr_err_early, // Pulse: answer came too early
   output logic atr_err_late, // Pulse: answer missing at window end
   output logic card_active, // Level: session in progress
   input wire logic card_ref_clk, // Link reference clock, 8 MHz
   output logic card_clock_out, // Card clock
   input wire logic card_data_in, // Data pin, input side
   output logic card_data_out, // Data pin, output side
   output logic card_data_oe_n, // Data pin enable, low while driving
   output logic card_reset_line, // Card reset
   input wire logic card_presence_detect, // Card present, active high
   output logic card_supply_en // Card supply enable
);
   typedef struct packed {
      logic start_tog;
      logic stop_tog;
      logic cfg;
      logic ok_seen;
      logic early_seen;
      logic late_seen;
      logic atr_ok;
      logic err_early;
      logic err_late;
      logic active;
   } scsq_mst_t;

   typedef struct packed {
      scsq_lstate_t state;
      logic low_rst;
      logic [15:0] cnt;
      logic [8:0] vcnt;
      logic clk_run;
      logic rst_line;
      logic data_rel;
      logic supply;
      logic data_prev;
      logic start_seen;
      logic stop_seen;
      logic ok_tog;
      logic early_tog;
      logic late_tog;
   } scsq_lst_t;

   scsq_mst_t m_reg;
   scsq_mst_t m_next;
   scsq_lst_t l_reg;
   scsq_lst_t l_next;

   logic lrst;
   logic [2:0] ctl_s;
   logic [1:0] pin_s;
   logic [3:0] ev_s;
   logic card_rise;
   logic data_fall;
   logic in_window;
   logic window_open;
   logic window_shut;

   // Link domain reset taken from the system reset
   scsq_sync3 #(.W(1)) u_rst_sync (
      .clk(card_ref_clk),
      .rst(1'b0),
      .din(sys_rst),
      .dout(lrst)
   );

   // Commands and card type into the link domain
   scsq_sync3 #(.W(3)) u_ctl_sync (
      .clk(card_ref_clk),
      .rst(lrst),
      .din({m_reg.start_tog, m_reg.stop_tog, m_reg.cfg}),
      .dout(ctl_s)
   );

   // Data and presence pins, each asynchronous to all else
   scsq_sync3 #(.W(2)) u_pin_sync (
      .clk(card_ref_clk),
      .rst(lrst),
      .din({card_data_in, card_presence_detect}),
      .dout(pin_s)
   );

   // Event toggles and the active level back to the system clock
   scsq_sync3 #(.W(4)) u_ev_sync (
      .clk(mclk),
      .rst(sys_rst),
      .din({l_reg.ok_tog, l_reg.early_tog, l_reg.late_tog, l_reg.supply}),
      .dout(ev_s)
   );

   // Card clock made here from the link reference
   scsq_clkdiv u_div (
      .clk(card_ref_clk),
      .rst(lrst),
      .run(l_reg.clk_run),
      .clk_out(card_clock_out),
      .rise(card_rise)
   );

   // System side: command toggles and event pulses
   always_comb begin
      m_next = m_reg;
      m_next.atr_ok = 1'b0;
      m_next.err_early = 1'b0;
      m_next.err_late = 1'b0;
      m_next.cfg = cfg_low_reset;
      if (act_start) begin
         m_next.start_tog = ~m_reg.start_tog;
      end
      if (act_stop) begin
         m_next.stop_tog = ~m_reg.stop_tog;
      end
      if (ev_s[3] != m_reg.ok_seen) begin
         m_next.ok_seen = ev_s[3];
         m_next.atr_ok = 1'b1;
      end
      if (ev_s[2] != m_reg.early_seen) begin
         m_next.early_seen = ev_s[2];
         m_next.err_early = 1'b1;
      end
      if (ev_s[1] != m_reg.late_seen) begin
         m_next.late_seen = ev_s[1];
         m_next.err_late = 1'b1;
      end
      m_next.active = ev_s[0];
      if (sys_rst) begin
         m_next = '0;
      end
   end

   always_ff @(posedge mclk) begin
      m_reg <= m_next;
   end

   // Answer window checks on the card cycle count
   assign data_fall = l_reg.data_rel & l_reg.data_prev & ~pin_s[1];
   assign in_window = (l_reg.state == L_WAIT_T0 && !l_reg.low_rst) ||
                      (l_reg.state == L_WAIT_T1);
   // The count parks at all ones until T0, which lies outside both windows
   assign window_open = l_reg.cnt >= ATR_MIN_CYC && l_reg.cnt != CNT_PRE_T0;
   assign window_shut = l_reg.cnt >= ATR_MAX && l_reg.cnt != CNT_PRE_T0;

   // Link side activation sequencer, counting card clock cycles
   always_comb begin
      l_next = l_reg;
      l_next.data_prev = pin_s[1];
      l_next.start_seen = ctl_s[2];
      l_next.stop_seen = ctl_s[1];
      if (card_rise) begin
         l_next.cnt = l_reg.cnt + 16'h0001;
      end
      case (l_reg.state)
         L_IDLE: begin
            l_next.cnt = 16'h0000;
            if (ctl_s[2] != l_reg.start_seen && pin_s[0]) begin
               l_next.state = L_POWER;
               l_next.low_rst = ctl_s[0];
               l_next.supply = 1'b1;
            end
         end
         L_POWER: begin
            // Supply settles, counted on the reference clock
            l_next.cnt = l_reg.cnt + 16'h0001;
            if (l_reg.cnt == POWER_UP_CYC) begin
               l_next.state = L_WAIT_T0;
               l_next.clk_run = 1'b1;
               l_next.cnt = CNT_PRE_T0;
            end
         end
         L_WAIT_T0: begin
            if (l_reg.cnt == DATA_REL_CYC) begin
               l_next.data_rel = 1'b1;
            end
            if (l_reg.low_rst) begin
               if (data_fall) begin
                  l_next.early_tog = ~l_reg.early_tog;
                  l_next.state = L_IDLE;
               end else if (card_rise && l_next.cnt == RST_HOLD) begin
                  l_next.state = L_WAIT_T1;
                  l_next.rst_line = 1'b1;
                  l_next.cnt = 16'h0000;
               end
            end else if (data_fall) begin
               if (window_open) begin
                  l_next.state = L_VERIFY;
                  l_next.vcnt = 9'h000;
               end else begin
                  l_next.early_tog = ~l_reg.early_tog;
                  l_next.state = L_IDLE;
               end
            end else if (window_shut) begin
               l_next.late_tog = ~l_reg.late_tog;
               l_next.state = L_IDLE;
            end
         end
         L_WAIT_T1: begin
            if (data_fall) begin
               if (window_open) begin
                  l_next.state = L_VERIFY;
                  l_next.vcnt = 9'h000;
               end else begin
                  l_next.early_tog = ~l_reg.early_tog;
                  l_next.state = L_IDLE;
               end
            end else if (window_shut) begin
               l_next.late_tog = ~l_reg.late_tog;
               l_next.state = L_IDLE;
            end
         end
         L_VERIFY: begin
            // Start bit must still be low at half a bit time
            if (card_rise) begin
               l_next.vcnt = l_reg.vcnt + 9'h001;
            end
            if (l_reg.vcnt == ETU_HALF_CYC) begin
               if (!pin_s[1]) begin
                  l_next.ok_tog = ~l_reg.ok_tog;
                  l_next.state = L_DONE;
               end else begin
                  l_next.state = l_reg.low_rst ? L_WAIT_T1 : L_WAIT_T0;
               end
            end
         end
         L_DONE: begin
            l_next.cnt = l_reg.cnt;
         end
         default: begin
            l_next.state = L_IDLE;
         end
      endcase
      // Session end on command or card removal powers the card down
      if (l_reg.state != L_IDLE &&
          (ctl_s[1] != l_reg.stop_seen || !pin_s[0] || l_next.state == L_IDLE)) begin
         l_next.state = L_IDLE;
         l_next.clk_run = 1'b0;
         l_next.rst_line = 1'b0;
         l_next.data_rel = 1'b0;
         l_next.supply = 1'b0;
      end
      if (lrst) begin
         l_next = '0;
         l_next.state = L_IDLE;
      end
   end

   always_ff @(posedge card_ref_clk) begin
      l_reg <= l_next;
   end

   // Outputs, each from a flip-flop except card_data_out, which is tied low
   assign atr_ok = m_reg.atr_ok;
   assign atr_err_early = m_reg.err_early;
   assign atr_err_late = m_reg.err_late;
   assign card_active = m_reg.active;
   assign card_data_out = 1'b0;
   assign card_data_oe_n = l_reg.data_rel;
   assign card_reset_line = l_reg.rst_line;
   assign card_supply_en = l_reg.supply;

   // Card clock alternates every reference cycle while running
   clk_duty_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (l_reg.clk_run && $past(l_reg.clk_run) && card_clock_out) |=> !card_clock_out)
      else $error("card clock high for more than one half period");

   // Clock stays parked while the card is unpowered
   clk_idle_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (!l_reg.supply) |-> ##1 !card_clock_out)
      else $error("card clock running without supply");

   // Data released well before the 200 cycle limit
   data_assert_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (l_reg.state == L_WAIT_T0 && l_reg.cnt > DATA_REL_CYC &&
       l_reg.cnt <= DATA_MAX_CYC) |-> card_data_oe_n)
      else $error("data line not asserted by cycle 200");

   // Reset held low through the whole first interval
   reset_low_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (l_reg.state == L_WAIT_T0 && l_reg.low_rst) |-> !card_reset_line)
      else $error("card reset released before T1");

   // Release at T1 only after the full hold count
   reset_rel_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      $rose(card_reset_line) |-> $past(l_reg.cnt) == RST_HOLD - 16'h0001 ||
      $past(l_reg.cnt) == RST_HOLD)
      else $error("card reset released at wrong count");

   // Reset stays high once the answer window after T1 is reached
   reset_hold_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (l_reg.state == L_WAIT_T1 || (l_reg.state == L_DONE && l_reg.low_rst))
      |-> card_reset_line)
      else $error("card reset dropped after T1");

   // An edge before the window opens is reported as early
   early_err_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (in_window && data_fall && !window_open && pin_s[0])
      |=> l_reg.early_tog != $past(l_reg.early_tog) && l_reg.state == L_IDLE)
      else $error("early answer not flagged");

   // No answer by the window end is reported as late
   late_err_a: assert property (
      @(posedge card_ref_clk) disable iff (lrst)
      (in_window && !data_fall && window_shut && pin_s[0])
      |=> l_reg.late_tog != $past(l_reg.late_tog))
      else $error("missing answer not flagged");

   // Good answer reaches the system side within a few cycles
   ok_event_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (ev_s[3] != m_reg.ok_seen) |=> atr_ok ##1 !atr_ok)
      else $error("answer event not pulsed once");
endmodule // scsq_top
`default_nettype wire

/* scsq_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scsq_card_model (
   input wire logic card_clock_out, // Card clock from the device
   input wire logic card_reset_line, // Card reset from the device
   input wire logic card_supply_en, // Card supply
   input wire logic low_reset_card, // 1: card waits for reset release
   input wire logic ignore_reset, // Misbehave: answer during reset hold
   input wire logic [31:0] atr_at, // Card cycle of answer start, 0 for none
   output logic card_pull_low // Card pulls the data line low
);
   int cnt = 0;
   int low_cnt = 0;
   logic started = 1'b0;
   logic sent = 1'b0;
   logic rst_prev = 1'b0;
   initial card_pull_low = 1'b0;

   // Count card cycles from T0, restart at T1, send one start bit
   always @(posedge card_clock_out or negedge card_supply_en) begin
      if (!card_supply_en) begin
         cnt = 0;
         started = 1'b0;
         sent = 1'b0;
         rst_prev = 1'b0;
         card_pull_low = 1'b0; // Unpowered card lets go of the line
      end else begin
         cnt = started ? cnt + 1 : 0;
         started = 1'b1;
         if (low_reset_card && card_reset_line && !rst_prev) begin
            cnt = 0;
         end
         rst_prev = card_reset_line;
         if (card_pull_low) begin
            low_cnt = low_cnt + 1;
            if (low_cnt == 372) begin
               card_pull_low = 1'b0;
            end
         end else if (!sent && atr_at != 0 && cnt == atr_at &&
                      (!low_reset_card || card_reset_line || ignore_reset)) begin
            card_pull_low = 1'b1;
            sent = 1'b1;
            low_cnt = 0;
         end
      end
   end
endmodule // scsq_card_model
`default_nettype wire

/* test_smart_card_reset_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_reset_sequencer;
   localparam logic [15:0] ATR_LIM = 16'h01F4;
   localparam logic [15:0] RST_LIM = 16'h0100;
   logic mclk = 1'b0;
   logic card_ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic act_start = 1'b0;
   logic act_stop = 1'b0;
   logic cfg_low_reset = 1'b0;
   logic card_presence_detect = 1'b0;
   logic rude = 1'b0;
   int atr_at = 0;
   logic atr_ok, atr_err_early, atr_err_late, card_active, card_clock_out;
   logic card_data_out, card_data_oe_n, card_reset_line, card_supply_en, card_pull_low;
   wire card_data_line;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int ccnt = -1;
   int rel_cnt = -1;
   int t1_cnt = -1;
   real t_rise = 0.0;
   real per = 0.0;
   real hi = 0.0;
   logic [2:0] ev;

   // Open-drain data line with pull-up
   assign card_data_line = !((!card_data_oe_n && !card_data_out) || card_pull_low);

   always #4 mclk = ~mclk;
   always #62.5 card_ref_clk = ~card_ref_clk;

   scsq_top #(.ATR_MAX(ATR_LIM), .RST_HOLD(RST_LIM)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .act_start(act_start), .act_stop(act_stop),
      .cfg_low_reset(cfg_low_reset), .atr_ok(atr_ok), .atr_err_early(atr_err_early),
      .atr_err_late(atr_err_late), .card_active(card_active), .card_ref_clk(card_ref_clk),
      .card_clock_out(card_clock_out), .card_data_in(card_data_line),
      .card_data_out(card_data_out), .card_data_oe_n(card_data_oe_n),
      .card_reset_line(card_reset_line), .card_presence_detect(card_presence_detect),
      .card_supply_en(card_supply_en));

   scsq_card_model card (
      .card_clock_out(card_clock_out), .card_reset_line(card_reset_line),
      .card_supply_en(card_supply_en), .low_reset_card(cfg_low_reset),
      .ignore_reset(rude), .atr_at(atr_at), .card_pull_low(card_pull_low));

   task automatic check_bit(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask

   task automatic check_range(input int v, input int lo, input int hi_v, input string msg);
      tests_run++;
      if (v < lo || v > hi_v) begin
         num_errors++;
         $display("Error %0t: %s (%0d)", $time, msg, v);
      end
   endtask

   task automatic stop_test();
      $display("Errors: %0d Comparisons: %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Card clock watcher: cycle count, release point, T1, period and high time
   always @(posedge card_clock_out) begin
      per = $realtime - t_rise;
      t_rise = $realtime;
      ccnt++;
      #1; // Let the pins launched on this edge settle
      if (card_data_oe_n && rel_cnt < 0) rel_cnt = ccnt;
      if (card_reset_line && t1_cnt < 0) t1_cnt = ccnt;
      if (t1_cnt >= 0 && card_supply_en) check_bit(card_reset_line, 1'b1, "reset dropped");
   end
   always @(negedge card_clock_out) begin
      if (card_supply_en) hi = $realtime - t_rise;
   end

   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 100000) begin
         num_errors++;
         $display("Error %0t: timeout", $time);
         stop_test();
      end
   end

   // Start a session and wait for the first event
   task automatic session(input logic low, input logic bad, input int at);
      int n;
      cfg_low_reset = low;
      rude = bad;
      atr_at = at;
      ccnt = -1;
      rel_cnt = -1;
      t1_cnt = -1;
      ev = 3'b000;
      @(negedge mclk) act_start = 1'b1;
      @(negedge mclk) act_start = 1'b0;
      n = 0;
      while (ev == 3'b000 && n < 40000) begin
         @(negedge mclk);
         n++;
         ev = {atr_ok, atr_err_early, atr_err_late};
      end
      check_range(rel_cnt, 0, 200, "data release late");
      check_range(int'(per), 200, 1000, "card clock rate");
      check_bit(hi * 2.0 == per, 1'b1, "card clock duty");
   endtask

   // Supply, clock, reset low and data driven low after session end
   task automatic power_down(input logic do_stop);
      int n;
      if (do_stop) begin
         @(negedge mclk) act_stop = 1'b1;
         @(negedge mclk) act_stop = 1'b0;
      end
      n = 0;
      while (card_supply_en && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check_bit(card_supply_en, 1'b0, "supply on");
      repeat (150) @(negedge mclk);
      check_bit(card_clock_out | card_reset_line | card_data_oe_n | card_data_out | card_active,
                1'b0, "pins not parked");
   endtask

   task automatic t_absent();
      @(negedge mclk) act_start = 1'b1;
      @(negedge mclk) act_start = 1'b0;
      repeat (150) @(negedge mclk);
      check_bit(card_supply_en, 1'b0, "start without card");
   endtask

   task automatic t_internal_ok();
      session(1'b0, 1'b0, 420);
      check_bit(ev === 3'b100, 1'b1, "internal answer");
      check_bit(card_active, 1'b1, "session not active");
      power_down(1'b1);
   endtask

   task automatic t_internal_early();
      session(1'b0, 1'b0, 300);
      check_bit(ev === 3'b010, 1'b1, "early answer");
      power_down(1'b0);
   endtask

   task automatic t_internal_late();
      session(1'b0, 1'b0, 0);
      check_bit(ev === 3'b001, 1'b1, "missing answer");
      check_range(ccnt, 499, 502, "late point");
      power_down(1'b0);
   endtask

   task automatic t_low_ok();
      session(1'b1, 1'b0, 420);
      check_bit(ev === 3'b100, 1'b1, "low reset answer");
      check_range(t1_cnt, 256, 258, "reset hold");
      power_down(1'b1);
   endtask

   task automatic t_low_hold_talk();
      session(1'b1, 1'b1, 200);
      check_bit(ev === 3'b010, 1'b1, "answer in hold");
      check_bit(t1_cnt < 0, 1'b1, "reset released");
      power_down(1'b0);
   endtask

   // Card pulled out mid-session: supply and pins drop with no command
   task automatic t_removed();
      cfg_low_reset = 1'b1;
      atr_at = 0;
      @(negedge mclk) act_start = 1'b1;
      @(negedge mclk) act_start = 1'b0;
      repeat (400) @(negedge mclk);
      check_bit(card_supply_en, 1'b1, "session not started");
      card_presence_detect = 1'b0;
      power_down(1'b0);
      card_presence_detect = 1'b1;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(negedge card_ref_clk);
      @(negedge mclk) sys_rst = 1'b0;
      check_bit(card_supply_en, 1'b0, "supply at reset");
      check_bit(card_data_oe_n, 1'b0, "data at reset");
      repeat (100) @(negedge mclk);
      t_absent();
      card_presence_detect = 1'b1;
      repeat (100) @(negedge mclk);
      t_internal_ok();
      t_internal_early();
      t_internal_late();
      t_low_ok();
      t_low_hold_talk();
      t_removed();
      stop_test();
   end
endmodule // test_smart_card_reset_sequencer
`default_nettype wire
